//--- logic/four_key_touch_detect.sv
/*
 * Key detection core: burst sequencing, thresholds, confirmation, suppression,
 * drift compensation, max on-duration recalibration and open-drain key outputs.
 * Assumes an analog front end on the same clock that runs a burst on request
 * and returns four pulse counts with a one-cycle done strobe; option pins are
 * asynchronous straps.
 */
module four_key_touch_detect #(
  parameter int MS_CYCLES = touch_detect_pkg::MS_CYCLES_DEF
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Option straps
  input wire logic key0_option_sense_pin,
  input wire logic key1_option_sense_pin,
  // Front end burst handshake
  output logic burst_start,
  output logic [touch_detect_pkg::SIG_W-1:0] burst_pulse_limit,
  input wire logic burst_done,
  input wire logic [3:0] chan_fitted,
  input wire logic [touch_detect_pkg::SIG_W-1:0] meas_ch0,
  input wire logic [touch_detect_pkg::SIG_W-1:0] meas_ch1,
  input wire logic [touch_detect_pkg::SIG_W-1:0] meas_ch2,
  input wire logic [touch_detect_pkg::SIG_W-1:0] meas_ch3,
  // Oscillator sweep code, half-percent steps
  output logic signed [5:0] osc_trim,
  // Open-drain key outputs, enable low drives the pin
  output logic touch_out_n_ch0,
  output logic touch_out_n_ch0_oe_n,
  output logic touch_out_n_ch1,
  output logic touch_out_n_ch1_oe_n,
  output logic touch_out_n_ch2,
  output logic touch_out_n_ch2_oe_n,
  output logic touch_out_n_ch3,
  output logic touch_out_n_ch3_oe_n
);
  import touch_detect_pkg::*;

  logic [1:0] k0_sync_reg, k1_sync_reg;
  logic [1:0] settle_reg, settle_next;
  logic single_key_suppression_reg, single_key_suppression_next;
  logic fast_mode_reg, fast_mode_next;
  seq_state_t state_reg, state_next;
  logic [24:0] div_reg, div_next;
  logic [15:0] sleep_ms_reg, sleep_ms_next;
  logic [15:0] up_ms_reg, up_ms_next, dn_ms_reg, dn_ms_next;
  logic up_due_reg, up_due_next, dn_due_reg, dn_due_next;
  logic cal_reg, cal_next;
  logic start_reg, start_next;
  logic signed [5:0] trim_reg, trim_next;
  logic trim_up_reg, trim_up_next;
  logic [SIG_W-1:0] sig [4];
  logic [SIG_W-1:0] cap_reg [4];
  logic [SIG_W-1:0] cap_next [4];
  logic [SIG_W-1:0] ref_reg [4];
  logic [SIG_W-1:0] ref_next [4];
  logic [2:0] cnt_reg [4];
  logic [2:0] cnt_next [4];
  logic [15:0] on_ms_reg [4];
  logic [15:0] on_ms_next [4];
  logic [3:0] det_reg, det_next, want, allow, over, below_rel, max_hit;
  logic ms_tick, any_det, eval;
  logic [3:0] touch_out_n_oe;

  // Strap synchronisers
  always_ff @(posedge clock) begin
    if (rst) begin
      k0_sync_reg <= 2'h0;
      k1_sync_reg <= 2'h0;
    end else begin
      k0_sync_reg <= {k0_sync_reg[0], key0_option_sense_pin};
      k1_sync_reg <= {k1_sync_reg[0], key1_option_sense_pin};
    end
  end

  // Millisecond enable from the clock divider
  assign ms_tick = (div_reg == 25'(MS_CYCLES - 1));
  assign any_det = |det_reg;
  assign eval = (state_reg == ST_EVAL);

  // Sequencer, straps, timers and sweep next values
  always_comb begin
    settle_next = settle_reg;
    single_key_suppression_next = single_key_suppression_reg;
    fast_mode_next = fast_mode_reg;
    state_next = state_reg;
    div_next = ms_tick ? 25'h000_0000 : div_reg + 25'h000_0001;
    sleep_ms_next = sleep_ms_reg;
    up_ms_next = up_ms_reg;
    dn_ms_next = dn_ms_reg;
    up_due_next = up_due_reg;
    dn_due_next = dn_due_reg;
    cal_next = cal_reg;
    start_next = 1'b0;
    trim_next = 6'sh00;
    trim_up_next = trim_up_reg;
    case (state_reg)
      ST_START: begin
        settle_next = settle_reg + 2'h1;
        if (settle_reg == STRAP_SETTLE) begin
          // R07 suppression strap
          single_key_suppression_next = k0_sync_reg[1];
          // R16 speed strap
          fast_mode_next = k1_sync_reg[1];
          state_next = ST_BURST;
          start_next = 1'b1;
        end
      end
      ST_SLEEP: begin
        // R17 R14 sleep length
        if (ms_tick) begin
          sleep_ms_next = sleep_ms_reg + 16'h0001;
          if (sleep_ms_reg + 16'h0001 >= (fast_mode_reg ? SLEEP_FAST_MS : SLEEP_SLOW_MS)) begin
            state_next = ST_BURST;
            start_next = 1'b1;
          end
        end
      end
      ST_BURST: begin
        // R11 triangle sweep of the oscillator
        trim_next = trim_up_reg ? trim_reg + 6'sh01 : trim_reg - 6'sh01;
        if (trim_up_reg && trim_reg >= SPREAD_LIMIT - 6'sh01) trim_up_next = 1'b0;
        if (!trim_up_reg && trim_reg <= -SPREAD_LIMIT + 6'sh01) trim_up_next = 1'b1;
        if (burst_done) begin
          state_next = ST_EVAL;
          trim_next = 6'sh00;
        end
      end
      ST_EVAL: begin
        state_next = ST_SLEEP;
        sleep_ms_next = 16'h0000;
        if (!any_det) begin
          up_due_next = 1'b0;
          dn_due_next = 1'b0;
        end
        // R12 recalibration after long detection
        cal_next = !cal_reg && |max_hit;
      end
      default: state_next = ST_START;
    endcase
    // R09 drift timers cleared while any key detects
    if (any_det) begin
      up_ms_next = 16'h0000;
      dn_ms_next = 16'h0000;
    end else if (ms_tick) begin
      // R10 asymmetric step rates
      up_ms_next = (up_ms_reg + 16'h0001 >= DRIFT_POS_MS) ? 16'h0000 : up_ms_reg + 16'h0001;
      dn_ms_next = (dn_ms_reg + 16'h0001 >= DRIFT_NEG_MS) ? 16'h0000 : dn_ms_reg + 16'h0001;
      if (up_ms_reg + 16'h0001 >= DRIFT_POS_MS) up_due_next = 1'b1;
      if (dn_ms_reg + 16'h0001 >= DRIFT_NEG_MS) dn_due_next = 1'b1;
    end
  end

  // Sequencer registers
  always_ff @(posedge clock) begin
    if (rst) begin
      settle_reg <= 2'h0;
      single_key_suppression_reg <= 1'b0;
      fast_mode_reg <= 1'b0;
      state_reg <= ST_START;
      div_reg <= 25'h000_0000;
      sleep_ms_reg <= 16'h0000;
      up_ms_reg <= 16'h0000;
      dn_ms_reg <= 16'h0000;
      up_due_reg <= 1'b0;
      dn_due_reg <= 1'b0;
      cal_reg <= 1'b1;
      start_reg <= 1'b0;
      trim_reg <= 6'sh00;
      trim_up_reg <= 1'b1;
    end else begin
      settle_reg <= settle_next;
      single_key_suppression_reg <= single_key_suppression_next;
      fast_mode_reg <= fast_mode_next;
      state_reg <= state_next;
      div_reg <= div_next;
      sleep_ms_reg <= sleep_ms_next;
      up_ms_reg <= up_ms_next;
      dn_ms_reg <= dn_ms_next;
      up_due_reg <= up_due_next;
      dn_due_reg <= dn_due_next;
      cal_reg <= cal_next;
      start_reg <= start_next;
      trim_reg <= trim_next;
      trim_up_reg <= trim_up_next;
    end
  end

  assign burst_start = start_reg;
  assign burst_pulse_limit = BURST_MAX;
  assign osc_trim = trim_reg;

  // R04 counts clamped to the burst limit
  assign sig[0] = (meas_ch0 > BURST_MAX) ? BURST_MAX : meas_ch0;
  assign sig[1] = (meas_ch1 > BURST_MAX) ? BURST_MAX : meas_ch1;
  assign sig[2] = (meas_ch2 > BURST_MAX) ? BURST_MAX : meas_ch2;
  assign sig[3] = (meas_ch3 > BURST_MAX) ? BURST_MAX : meas_ch3;

  // R05 R06 under suppression one grant at a time, lowest key first
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      allow[i] = !single_key_suppression_reg || !any_det;
      for (int j = 0; j < i; j++) begin
        if (single_key_suppression_reg && want[j]) allow[i] = 1'b0;
      end
    end
  end

  generate
    for (genvar k = 0; k < 4; k++) begin : g_key
      logic signed [SIG_W:0] delta;
      // R01 R02 change measured toward touch
      assign delta = $signed({1'b0, ref_reg[k]}) - $signed({1'b0, cap_reg[k]});
      assign over[k] = (delta >= ENTRY_THRESH);
      assign below_rel[k] = (delta < RELEASE_THRESH);
      // R03 fifth confirmation wants detect
      assign want[k] = chan_fitted[k] && !det_reg[k] && over[k]
                       && (cnt_reg[k] == CONFIRM_COUNT - 3'h1);
      assign max_hit[k] = (on_ms_reg[k] >= MAX_ON_MS);

      // Per-key detection next values
      always_comb begin
        // Counts are only valid on the done cycle, so hold them for the evaluation
        cap_next[k] = (state_reg == ST_BURST && burst_done) ? sig[k] : cap_reg[k];
        ref_next[k] = ref_reg[k];
        cnt_next[k] = cnt_reg[k];
        det_next[k] = det_reg[k];
        on_ms_next[k] = det_reg[k] ? on_ms_reg[k] + {15'h0000, ms_tick} : 16'h0000;
        if (eval) begin
          if (cal_reg || !chan_fitted[k]) begin
            // R13 R18 disabled key held idle
            ref_next[k] = cap_reg[k];
            cnt_next[k] = 3'h0;
            det_next[k] = 1'b0;
          end else if (det_reg[k]) begin
            // R02 hysteresis release
            if (below_rel[k]) det_next[k] = 1'b0;
            cnt_next[k] = 3'h0;
          end else if (over[k]) begin
            // R03 confirmation counting
            cnt_next[k] = (cnt_reg[k] == CONFIRM_COUNT - 3'h1) ? cnt_reg[k] : cnt_reg[k] + 3'h1;
            if (want[k] && allow[k]) begin
              det_next[k] = 1'b1;
              cnt_next[k] = 3'h0;
            end
          end else begin
            cnt_next[k] = 3'h0;
          end
          // R08 R09 R10 slow reference tracking
          if (!cal_reg && chan_fitted[k] && !any_det) begin
            if (cap_reg[k] < ref_reg[k] && dn_due_reg) ref_next[k] = ref_reg[k] - 12'h001;
            if (cap_reg[k] > ref_reg[k] && up_due_reg) ref_next[k] = ref_reg[k] + 12'h001;
          end
        end
      end

      // Per-key registers
      always_ff @(posedge clock) begin
        if (rst) begin
          cap_reg[k] <= 12'h000;
          ref_reg[k] <= 12'h000;
          cnt_reg[k] <= 3'h0;
          det_reg[k] <= 1'b0;
          on_ms_reg[k] <= 16'h0000;
        end else begin
          cap_reg[k] <= cap_next[k];
          ref_reg[k] <= ref_next[k];
          cnt_reg[k] <= cnt_next[k];
          det_reg[k] <= det_next[k];
          on_ms_reg[k] <= on_ms_next[k];
        end
      end

      property p_entry_confirmed;
        @(posedge clock) disable iff (rst)
        $rose(det_reg[k]) |-> $past(cnt_reg[k]) == CONFIRM_COUNT - 3'h1 && $past(over[k]);
      endproperty
      a_entry_confirmed: assert property (p_entry_confirmed) // R03 R01
        else $error("Key entered detect without five confirmations");
      property p_release_hyst;
        @(posedge clock) disable iff (rst)
        $fell(det_reg[k]) |-> $past(below_rel[k] || cal_reg || !chan_fitted[k]);
      endproperty
      a_release_hyst: assert property (p_release_hyst) // R02
        else $error("Key released while change still at release level");
      property p_disabled_idle;
        @(posedge clock) disable iff (rst)
        (eval && !chan_fitted[k]) |=> !det_reg[k] && touch_out_n_oe[k];
      endproperty
      a_disabled_idle: assert property (p_disabled_idle) // R18
        else $error("Disabled key shows detect");
      property p_drift_frozen;
        @(posedge clock) disable iff (rst)
        (eval && any_det && !cal_reg) |=> $stable(ref_reg[k]);
      endproperty
      a_drift_frozen: assert property (p_drift_frozen) // R09
        else $error("Reference moved while a key detects");
      property p_ref_bounded;
        @(posedge clock) disable iff (rst)
        ref_reg[k] <= BURST_MAX;
      endproperty
      a_ref_bounded: assert property (p_ref_bounded) // R04
        else $error("Reference beyond burst limit");
      property p_out_follows;
        @(posedge clock) disable iff (rst)
        !eval |=> $stable(touch_out_n_oe[k]);
      endproperty
      a_out_follows: assert property (p_out_follows) // R15
        else $error("Key output changed outside an evaluation");
    end
  endgenerate

  // R15 open-drain drive low while touched
  assign touch_out_n_oe = ~det_reg;
  assign touch_out_n_ch0 = 1'b0;
  assign touch_out_n_ch1 = 1'b0;
  assign touch_out_n_ch2 = 1'b0;
  assign touch_out_n_ch3 = 1'b0;
  assign touch_out_n_ch0_oe_n = touch_out_n_oe[0];
  assign touch_out_n_ch1_oe_n = touch_out_n_oe[1];
  assign touch_out_n_ch2_oe_n = touch_out_n_oe[2];
  assign touch_out_n_ch3_oe_n = touch_out_n_oe[3];

  property p_single_key;
    @(posedge clock) disable iff (rst)
    single_key_suppression_reg |-> $onehot0(det_reg);
  endproperty
  a_single_key: assert property (p_single_key) // R05
    else $error("More than one key in detect under suppression");
  property p_spread_range;
    @(posedge clock) disable iff (rst)
    (state_reg != ST_BURST) |=> (trim_reg == 6'sh00 || $past(state_reg) == ST_BURST)
      && trim_reg <= SPREAD_LIMIT && trim_reg >= -SPREAD_LIMIT;
  endproperty
  a_spread_range: assert property (p_spread_range) // R11
    else $error("Oscillator sweep outside its range or outside a burst");
endmodule : four_key_touch_detect

//--- include/touch_detect_pkg.sv
/*
 * Constants, timing figures and state encoding for the four-key touch detector.
 * Assumes a single 25 MHz clock and a burst front end that returns one count per key.
 */
// Operation
// R01: Key is over threshold when change from reference reaches 10 counts, fixed.
// R02: Key in detect releases only when its change drops below 8 counts.
// R03: Per-key counter confirms touch after 5 consecutive over-threshold acquisitions.
// R04: One burst never exceeds 2048 pulses; the pulse count is the key signal.
// R05: Suppression on: all keys form one group, at most one reported touched.
// R06: Suppression off: any combination of keys may be in detect together.
// R07: Suppression is on when the key-0 option pin is strapped to supply.
// R08: Reference tracks raw signal slowly while no detection is in effect.
// R09: Drift stops on all keys whenever any key is in detect.
// R10: Drift toward touch steps every 3 s, away from touch every 1 s.
// R11: Oscillator is swept over plus or minus 7.5 percent during each burst.
// R12: Detection lasting beyond about 30 s forces a recalibration of references.
// R13: One to four keys; a key without sample capacitor is disabled.
// R14: Slow mode waits longer between bursts than fast mode.
// R15: Each key has an active-low open-drain output asserted while touched.
// R16: Key-1 option pin to supply selects fast mode, to ground slow mode.
// R17: Sleep between bursts is 16 ms in fast mode, 64 ms in slow mode.
// R18: Disabled key never detects, is outside suppression, output stays inactive.
package touch_detect_pkg;
  // ==========================================================
  // Widths and detection figures
  localparam int SIG_W = 12;
  localparam logic [SIG_W-1:0] BURST_MAX = 12'h0800;
  localparam logic signed [SIG_W:0] ENTRY_THRESH = 13'sh000A;
  localparam logic signed [SIG_W:0] RELEASE_THRESH = 13'sh0008;
  localparam logic [2:0] CONFIRM_COUNT = 3'h5;
  // ==========================================================
  // Timing, each in its own unit, then derived
  localparam int CLOCK_HZ = 32'h017D_7840;
  localparam int MS_CYCLES_DEF = CLOCK_HZ / 32'h0000_03E8;
  localparam logic [15:0] SLEEP_FAST_MS = 16'h0010;
  localparam logic [15:0] SLEEP_SLOW_MS = 16'h0040;
  localparam int DRIFT_NEG_S = 32'h0000_0003;
  localparam int DRIFT_POS_S = 32'h0000_0001;
  localparam int MAX_ON_S = 32'h0000_001E;
  localparam logic [15:0] DRIFT_NEG_MS = 16'(DRIFT_NEG_S * 32'h0000_03E8);
  localparam logic [15:0] DRIFT_POS_MS = 16'(DRIFT_POS_S * 32'h0000_03E8);
  localparam logic [15:0] MAX_ON_MS = 16'(MAX_ON_S * 32'h0000_03E8);
  localparam logic [1:0] STRAP_SETTLE = 2'h3;
  // ==========================================================
  // Spread sweep in half-percent steps: 7.5 percent is 15 steps
  localparam int SPREAD_PCT_X10 = 32'h0000_004B;
  localparam int SPREAD_STEP_X10 = 32'h0000_0005;
  localparam logic signed [5:0] SPREAD_LIMIT = 6'(SPREAD_PCT_X10 / SPREAD_STEP_X10);
  // ==========================================================
  // Sequencer states
  typedef enum logic [1:0] {
    ST_START = 2'b00,
    ST_SLEEP = 2'b01,
    ST_BURST = 2'b10,
    ST_EVAL = 2'b11
  } seq_state_t;
endpackage : touch_detect_pkg

//--- test/front_end_model.sv
/* Front end and host pin model for the touch detector.
   Assumes the bench sets levels and burst delay; key lines have pull-ups. */
module front_end_model (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Burst request and answer
  input wire logic burst_start,
  input wire logic [7:0] delay_cycles,
  input wire logic [3:0][touch_detect_pkg::SIG_W-1:0] level,
  output logic burst_done,
  output logic [3:0][touch_detect_pkg::SIG_W-1:0] meas,
  // Open-drain key lines
  input wire logic [3:0] pin_out,
  input wire logic [3:0] pin_oe_n,
  output logic [3:0] pin_n
);
  timeunit 1ns;
  timeprecision 1ns;
  import touch_detect_pkg::*;
  logic busy = 1'b0;
  logic [7:0] left = 8'h00;
  logic last;
  // ==========================================================
  // Burst answer
  // Counts are valid on the done cycle only, and toggle otherwise
  initial burst_done = 1'b0;
  initial meas = '0;
  assign last = busy && left <= 8'h01;
  always @(posedge clock) begin
    burst_done <= !rst && last;
    meas <= last ? level : ~meas;
    if (rst || last) begin
      busy <= 1'b0;
    end else if (burst_start) begin
      busy <= 1'b1;
      left <= delay_cycles;
    end else begin
      left <= left - 8'h01;
    end
  end
  assign pin_n = pin_oe_n | pin_out;
endmodule : front_end_model

//--- test/tb_top.sv
/* Bench for the four-key touch detector: stimulus, reference model, verdict.
   Assumes the front end model and a one-clock millisecond tick. */
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import touch_detect_pkg::*;
  // ==========================================================
  // Signals and model state
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic sup_pin = 1'b0;
  logic fast_pin = 1'b1;
  logic [3:0] fitted = 4'hF;
  logic [7:0] dly = 8'h04;
  logic [3:0][SIG_W-1:0] level = '0;
  logic [3:0][SIG_W-1:0] meas;
  logic burst_start, burst_done;
  logic [SIG_W-1:0] pulse_limit;
  logic signed [5:0] osc_trim;
  logic [3:0] od_out, od_oe_n, pin_n;
  int bad_count = 0;
  int checks = 0;
  int seed = 32'hf8ea;
  int cyc = 0;
  int cmp_at = -1;
  int lo_t = 0;
  int hi_t = 0;
  int base[4], ref_m[4], cnt_m[4], on_t[4], cv[4];
  bit det_m[4];
  bit cal_m, sup_m, fast_m;
  int acc_p, acc_n, last_e, done_at, skip_to;
  // Clock
  always #20 clock = ~clock;
  four_key_touch_detect #(.MS_CYCLES(1)) dut (
    .clock(clock), .rst(rst), .key0_option_sense_pin(sup_pin),
    .key1_option_sense_pin(fast_pin), .burst_start(burst_start),
    .burst_pulse_limit(pulse_limit), .burst_done(burst_done), .chan_fitted(fitted),
    .meas_ch0(meas[0]), .meas_ch1(meas[1]), .meas_ch2(meas[2]), .meas_ch3(meas[3]),
    .osc_trim(osc_trim),
    .touch_out_n_ch0(od_out[0]), .touch_out_n_ch0_oe_n(od_oe_n[0]),
    .touch_out_n_ch1(od_out[1]), .touch_out_n_ch1_oe_n(od_oe_n[1]),
    .touch_out_n_ch2(od_out[2]), .touch_out_n_ch2_oe_n(od_oe_n[2]),
    .touch_out_n_ch3(od_out[3]), .touch_out_n_ch3_oe_n(od_oe_n[3]));
  front_end_model fe (
    .clock(clock), .rst(rst), .burst_start(burst_start), .delay_cycles(dly),
    .level(level), .burst_done(burst_done), .meas(meas),
    .pin_out(od_out), .pin_oe_n(od_oe_n), .pin_n(pin_n));
  // ==========================================================
  // Compare and verdict
  task automatic check(input logic ok, input string msg);
    checks++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask : check
  task automatic stop_test;
    if (bad_count == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : stop_test
  // Reference model of one evaluation
  task automatic model_eval;
    int d, any0, any;
    bit hit;
    hit = 0;
    any0 = 0;
    for (int k = 0; k < 4; k++) begin
      cv[k] = meas[k] > BURST_MAX ? BURST_MAX : meas[k];
      any0 |= det_m[k];
      if (det_m[k] && cyc - on_t[k] > MAX_ON_MS - 100) skip_to = cyc + 400;
      if (det_m[k] && cyc - on_t[k] >= MAX_ON_MS) hit = 1;
    end
    if (cal_m || hit) begin
      for (int k = 0; k < 4; k++) begin
        if (cal_m) ref_m[k] = cv[k];
        det_m[k] = 0;
        cnt_m[k] = 0;
      end
      cal_m = hit;
      return;
    end
    any = any0;
    for (int k = 0; k < 4; k++) begin
      d = ref_m[k] - cv[k];
      if (!fitted[k]) begin
        ref_m[k] = cv[k];
      end else if (det_m[k]) begin
        det_m[k] = d >= RELEASE_THRESH;
        cnt_m[k] = 0;
      end else if (d >= ENTRY_THRESH) begin
        cnt_m[k]++;
        if (cnt_m[k] >= CONFIRM_COUNT && sup_m && any) begin
          cnt_m[k] = CONFIRM_COUNT - 1;
        end else if (cnt_m[k] >= CONFIRM_COUNT) begin
          det_m[k] = 1;
          on_t[k] = cyc;
          any = 1;
        end
      end else begin
        cnt_m[k] = 0;
      end
    end
    if (!any0) begin
      acc_p += cyc - last_e;
      acc_n += cyc - last_e;
      for (int k = 0; k < 4; k++) begin
        if (acc_p >= DRIFT_POS_MS && cv[k] > ref_m[k]) ref_m[k]++;
        if (acc_n >= DRIFT_NEG_MS && cv[k] < ref_m[k]) ref_m[k]--;
      end
      if (acc_p >= DRIFT_POS_MS) acc_p -= DRIFT_POS_MS;
      if (acc_n >= DRIFT_NEG_MS) acc_n -= DRIFT_NEG_MS;
    end else begin
      // Drift timers restart once every key is released
      acc_p = 0;
      acc_n = 0;
    end
    last_e = cyc;
  endtask : model_eval
  // Model updates, output compares and timing checks
  always @(posedge clock) begin
    int sl;
    cyc <= cyc + 1;
    sl = fast_m ? SLEEP_FAST_MS : SLEEP_SLOW_MS;
    if (rst) begin
      cal_m = 1'b1;
      sup_m = sup_pin;
      fast_m = fast_pin;
      acc_p = 0;
      acc_n = 0;
      done_at = 0;
      last_e = cyc;
      det_m = '{default: 0};
    end else begin
      if (burst_done) begin
        model_eval();
        cmp_at = cyc + 3;
        done_at = cyc;
        dly <= (($random(seed) & 7) == 0) ? 8'h46 : 8'(1 + ($random(seed) & 7));
      end
      if (cyc == cmp_at && cyc > skip_to) begin
        for (int k = 0; k < 4; k++) begin
          check(pin_n[k] === !det_m[k], "key output differs from model");
        end
        check(od_out === 4'h0, "key drive level");
      end
      if (burst_start) begin
        check(osc_trim === 6'sh00 && pulse_limit === BURST_MAX, "burst start");
        if (done_at > 0) check(cyc - done_at >= sl && cyc - done_at <= sl + 8, "sleep");
      end
      check(osc_trim <= SPREAD_LIMIT && osc_trim >= -SPREAD_LIMIT, "trim range");
      check((pin_n | fitted) === 4'hF && (!sup_m || $countones(~pin_n) <= 1), "group");
      lo_t = osc_trim < lo_t ? osc_trim : lo_t;
      hi_t = osc_trim > hi_t ? osc_trim : hi_t;
    end
  end
  // ==========================================================
  // Stimulus
  task automatic restart(input logic sup, input logic fast, input logic [3:0] fit);
    rst <= 1'b1;
    sup_pin <= sup;
    fast_pin <= fast;
    fitted <= fit;
    for (int k = 0; k < 4; k++) level[k] <= SIG_W'(base[k]);
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    repeat (2) @(posedge clock iff burst_done);
  endtask : restart
  // Lower each key by its offset, then let n evaluations pass
  task automatic run(input int d[4], input int n);
    for (int k = 0; k < 4; k++) level[k] <= SIG_W'(base[k] - d[k]);
    repeat (n) @(posedge clock iff burst_done);
  endtask : run
  // Watchdog sized from the longest expected run
  initial begin
    repeat (32'h0001_86A0) @(posedge clock);
    bad_count++;
    $display("CHECK FAILED at %0t: watchdog", $time);
    stop_test();
  end
  // Main sequence
  initial begin
    for (int k = 0; k < 4; k++) base[k] = 32'h0000_0258 + ($random(seed) & 32'h0000_00FF);
    restart(1'b0, 1'b1, 4'hF);
    run('{10, 9, 20, 0}, 4);
    run('{10, 9, 0, 0}, 1);
    run('{10, 9, 20, 0}, 5);
    run('{8, 9, 20, 0}, 3);
    run('{7, 9, 7, 0}, 2);
    restart(1'b1, 1'b1, 4'hF);
    run('{20, 20, 0, 0}, 6);
    run('{0, 20, 0, 0}, 3);
    base[3] = 32'h0000_0FA0;
    restart(1'b1, 1'b1, 4'hE);
    run('{30, 20, 0, 1960}, 6);
    base[3] = base[0];
    restart(1'b0, 1'b0, 4'hF);
    run('{0, 0, 0, 0}, 3);
    restart(1'b0, 1'b1, 4'hF);
    run('{-3, 3, 0, 0}, 400);
    run('{8, 12, 0, 0}, 6);
    run('{8, -5, 0, 0}, 200);
    run('{-3, 9, 0, 0}, 6);
    run('{0, 0, 20, 0}, 6);
    repeat (32'h0000_7918) @(posedge clock);
    check(pin_n === 4'hF, "max on-duration");
    check(hi_t == SPREAD_LIMIT && lo_t == -SPREAD_LIMIT, "sweep span");
    stop_test();
  end
endmodule : tb_top
